// file: logic/dcr_pkg.sv
// Package with register map, field layout and reset values of the DMA routing block.
`default_nettype none
package dcr_pkg;
  // ****************************************
  // Register indices, in word units of the register bus.
  // ****************************************
  localparam int unsigned SRC_IDX_BASE = 'h80;
  localparam int unsigned DST_IDX_BASE = 'h82;
  localparam int unsigned CHAN_IDX_STRIDE = 8;
  localparam int unsigned ROUTE_IDX = 'h7c;
  localparam int unsigned CTRL_IDX = 'h7d;
  localparam int unsigned STAT_IDX = 'h7e;
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned ADDR_W = 10;
  // ****************************************
  // Field layout.
  // ****************************************
  localparam int unsigned SEL_W = 4;
  localparam int unsigned CTRL_START_LSB = 0;
  localparam int unsigned CTRL_SIZE_LSB = 8;
  localparam int unsigned STAT_BUSY_LSB = 0;
  // ****************************************
  // Reset values and the read value of unmapped indices.
  // ****************************************
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [3:0] SEL_RST = 4'h0;
  localparam logic [1:0] SIZE_RST = 2'h0;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
  typedef enum logic [1:0] {
    DCR_SZ8,
    DCR_SZ16,
    DCR_SZ32
  } dcr_size_t;
  typedef enum {
    DCR_IDLE,
    DCR_WAIT_REQ,
    DCR_READ,
    DCR_WRITE
  } dcr_state_t;
endpackage
`default_nettype wire

// file: logic/dcr_req_mux.sv
// Request routing mux: one of sixteen peripheral requests per channel.
`default_nettype none
module dcr_req_mux #(
  parameter int unsigned NUM_REQ = 16
) (
  input wire logic [NUM_REQ-1:0] periph_req,
  input wire logic [3:0] sel,
  input wire logic ack,
  input wire logic done,
  output logic chan_req,
  output logic [NUM_REQ-1:0] periph_ack,
  output logic [NUM_REQ-1:0] periph_done
);
  // The four-bit selector cannot reach more or fewer than sixteen requests.
  if (NUM_REQ != 16) begin : g_bad_req
    $error("Selector width serves exactly sixteen requests.");
  end

  // Code n picks request n, codes 0000 to 1111.
  assign chan_req = periph_req[sel];

  genvar g;
  generate
    for (g = 0; g < NUM_REQ; g++) begin : g_ret
      // Only the selected peripheral sees the answer.
      assign periph_ack[g] = ack && (sel == 4'(g));
      assign periph_done[g] = done && (sel == 4'(g));
    end
  endgenerate
endmodule
`default_nettype wire

// file: logic/dcr_top.sv
// Four-channel DMA address registers, request routing and transfer engine.
`default_nettype none
module dcr_top #(
  parameter int unsigned NUM_REQ = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [dcr_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NUM_REQ-1:0] periph_req,
  output logic [NUM_REQ-1:0] periph_ack,
  output logic [NUM_REQ-1:0] periph_done,
  output logic mem_read,
  output logic mem_write,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  input wire logic mem_ready
);
  localparam int unsigned NC = dcr_pkg::NUM_CHAN;

  if (NUM_REQ != 16) begin : g_bad_req
    $error("Routing supports sixteen requests only.");
  end

  // ****************************************
  // Address decode helpers.
  // ****************************************
  function automatic logic [dcr_pkg::ADDR_W-1:0] src_idx(input int unsigned c);
    src_idx = dcr_pkg::ADDR_W'(dcr_pkg::SRC_IDX_BASE
      + dcr_pkg::CHAN_IDX_STRIDE * c);
  endfunction

  function automatic logic [dcr_pkg::ADDR_W-1:0] dst_idx(input int unsigned c);
    dst_idx = dcr_pkg::ADDR_W'(dcr_pkg::DST_IDX_BASE
      + dcr_pkg::CHAN_IDX_STRIDE * c);
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    merge_be = r;
  endfunction

  function automatic logic [31:0] size_step(input logic [1:0] sz);
    unique case (sz)
      dcr_pkg::DCR_SZ16: size_step = 32'h0000_0002;
      dcr_pkg::DCR_SZ32: size_step = 32'h0000_0004;
      default: size_step = 32'h0000_0001;
    endcase
  endfunction

  // ****************************************
  // Register state.
  // ****************************************
  logic [31:0] src_byte_addr_r [NC];
  logic [31:0] src_byte_addr_nxt [NC];
  logic [31:0] dst_byte_addr_r [NC];
  logic [31:0] dst_byte_addr_nxt [NC];
  logic [15:0] request_routing_reg_r;
  logic [15:0] request_routing_reg_nxt;
  logic [1:0] size_r [NC];
  logic [1:0] size_nxt [NC];
  logic [31:0] avs_readdata_r;
  logic [31:0] avs_readdata_nxt;
  logic ack_done_r;
  logic ack_done_nxt;

  // Engine state.
  dcr_pkg::dcr_state_t state_r;
  dcr_pkg::dcr_state_t state_nxt;
  logic [1:0] chan_r;
  logic [1:0] chan_nxt;
  logic [NC-1:0] armed_r;
  logic [NC-1:0] armed_nxt;
  logic [31:0] mem_addr_r;
  logic [31:0] mem_addr_nxt;
  logic [1:0] mem_size_r;
  logic [1:0] mem_size_nxt;

  // ****************************************
  // Request routing per channel.
  // ****************************************
  logic [NC-1:0] chan_req;
  logic [NC-1:0] chan_ack;
  logic [NC-1:0] chan_done;
  logic [NUM_REQ-1:0] ack_vec [NC];
  logic [NUM_REQ-1:0] done_vec [NC];

  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_rt
      dcr_req_mux #(.NUM_REQ(NUM_REQ)) u_mux (
        .periph_req(periph_req),
        .sel(request_routing_reg_r[4*g +: 4]),
        .ack(chan_ack[g]),
        .done(chan_done[g]),
        .chan_req(chan_req[g]),
        .periph_ack(ack_vec[g]),
        .periph_done(done_vec[g])
      );
      assign chan_ack[g] = (chan_r == 2'(g)) && mem_write && mem_ready;
      assign chan_done[g] = chan_ack[g];
    end
  endgenerate

  always_comb begin
    periph_ack = '0;
    periph_done = '0;
    for (int c = 0; c < NC; c++) begin
      periph_ack = periph_ack | ack_vec[c];
      periph_done = periph_done | done_vec[c];
    end
  end

  // ****************************************
  // Transfer engine: one read then one write per request.
  // ****************************************
  logic eng_step;
  assign eng_step = mem_ready && (state_r == dcr_pkg::DCR_WRITE);

  always_comb begin
    state_nxt = state_r;
    chan_nxt = chan_r;
    mem_read = 1'b0;
    mem_write = 1'b0;
    unique case (state_r)
      dcr_pkg::DCR_IDLE: begin
        if (|armed_r) begin
          state_nxt = dcr_pkg::DCR_WAIT_REQ;
        end
      end
      dcr_pkg::DCR_WAIT_REQ: begin
        // Lowest channel wins; fixed priority keeps the engine simple.
        for (int c = NC - 1; c >= 0; c--) begin
          if (armed_r[c] && chan_req[c]) begin
            chan_nxt = 2'(c);
            state_nxt = dcr_pkg::DCR_READ;
          end
        end
        if (~|armed_r) begin
          state_nxt = dcr_pkg::DCR_IDLE;
        end
      end
      dcr_pkg::DCR_READ: begin
        mem_read = 1'b1;
        if (mem_ready) begin
          state_nxt = dcr_pkg::DCR_WRITE;
        end
      end
      dcr_pkg::DCR_WRITE: begin
        mem_write = 1'b1;
        if (mem_ready) begin
          state_nxt = dcr_pkg::DCR_IDLE;
        end
      end
    endcase
    // Address and size come from flip-flops. They load the next-cycle
    // register values, so they always match the state they go with.
    mem_size_nxt = size_nxt[chan_nxt];
    mem_addr_nxt = 32'h0000_0000;
    if (state_nxt == dcr_pkg::DCR_READ) begin
      mem_addr_nxt = src_byte_addr_nxt[chan_nxt];
    end else if (state_nxt == dcr_pkg::DCR_WRITE) begin
      mem_addr_nxt = dst_byte_addr_nxt[chan_nxt];
    end
  end

  // ****************************************
  // Avalon-MM slave and register updates.
  // ****************************************
  // Reads take one wait cycle so read data come from a flip-flop.
  assign avs_waitrequest = avs_read && !ack_done_r;
  assign avs_readdata = avs_readdata_r;
  assign mem_addr = mem_addr_r;
  assign mem_size = mem_size_r;

  always_comb begin
    request_routing_reg_nxt = request_routing_reg_r;
    armed_nxt = armed_r;
    avs_readdata_nxt = avs_readdata_r;
    ack_done_nxt = avs_read && !ack_done_r;
    for (int c = 0; c < NC; c++) begin
      src_byte_addr_nxt[c] = src_byte_addr_r[c];
      dst_byte_addr_nxt[c] = dst_byte_addr_r[c];
      size_nxt[c] = size_r[c];
    end
    // Advance the addresses after each completed beat.
    if (mem_ready && state_r == dcr_pkg::DCR_READ) begin
      src_byte_addr_nxt[chan_r] = src_byte_addr_r[chan_r]
        + size_step(size_r[chan_r]);
    end
    if (eng_step) begin
      dst_byte_addr_nxt[chan_r] = dst_byte_addr_r[chan_r]
        + size_step(size_r[chan_r]);
      armed_nxt[chan_r] = 1'b0;
    end
    if (avs_write) begin
      for (int c = 0; c < NC; c++) begin
        if (avs_address == src_idx(c)) begin
          src_byte_addr_nxt[c] = merge_be(src_byte_addr_r[c], avs_writedata,
                                          avs_byteenable);
        end
        if (avs_address == dst_idx(c)) begin
          dst_byte_addr_nxt[c] = merge_be(dst_byte_addr_r[c], avs_writedata,
                                          avs_byteenable);
        end
      end
      if (avs_address == dcr_pkg::ADDR_W'(dcr_pkg::ROUTE_IDX)) begin
        request_routing_reg_nxt = 16'(merge_be({16'h0000,
          request_routing_reg_r}, avs_writedata, avs_byteenable));
      end
      if (avs_address == dcr_pkg::ADDR_W'(dcr_pkg::CTRL_IDX)) begin
        for (int c = 0; c < NC; c++) begin
          // A new arm written during completion wins over the clear.
          if (avs_writedata[dcr_pkg::CTRL_START_LSB + c]) begin
            armed_nxt[c] = 1'b1;
          end
          size_nxt[c] = avs_writedata[dcr_pkg::CTRL_SIZE_LSB + 2*c +: 2];
        end
      end
    end
    if (avs_read && !ack_done_r) begin
      avs_readdata_nxt = dcr_pkg::UNMAPPED_RD;
      for (int c = 0; c < NC; c++) begin
        if (avs_address == src_idx(c)) begin
          avs_readdata_nxt = src_byte_addr_r[c];
        end
        if (avs_address == dst_idx(c)) begin
          avs_readdata_nxt = dst_byte_addr_r[c];
        end
      end
      if (avs_address == dcr_pkg::ADDR_W'(dcr_pkg::ROUTE_IDX)) begin
        avs_readdata_nxt = {16'h0000, request_routing_reg_r};
      end
      if (avs_address == dcr_pkg::ADDR_W'(dcr_pkg::CTRL_IDX)) begin
        avs_readdata_nxt = 32'h0000_0000;
        for (int c = 0; c < NC; c++) begin
          avs_readdata_nxt[dcr_pkg::CTRL_SIZE_LSB + 2*c +: 2] = size_r[c];
        end
        avs_readdata_nxt[NC-1:0] = armed_r;
      end
      if (avs_address == dcr_pkg::ADDR_W'(dcr_pkg::STAT_IDX)) begin
        avs_readdata_nxt = {28'h0000000, chan_req};
        avs_readdata_nxt[dcr_pkg::STAT_BUSY_LSB + 4] =
          (state_r == dcr_pkg::DCR_READ) || (state_r == dcr_pkg::DCR_WRITE);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int c = 0; c < NC; c++) begin
        src_byte_addr_r[c] <= dcr_pkg::ADDR_RST;
        dst_byte_addr_r[c] <= dcr_pkg::ADDR_RST;
        size_r[c] <= dcr_pkg::SIZE_RST;
      end
      request_routing_reg_r <= {4{dcr_pkg::SEL_RST}};
      armed_r <= '0;
      avs_readdata_r <= 32'h0000_0000;
      ack_done_r <= 1'b0;
      state_r <= dcr_pkg::DCR_IDLE;
      chan_r <= 2'h0;
      mem_addr_r <= 32'h0000_0000;
      mem_size_r <= dcr_pkg::SIZE_RST;
    end else begin
      for (int c = 0; c < NC; c++) begin
        src_byte_addr_r[c] <= src_byte_addr_nxt[c];
        dst_byte_addr_r[c] <= dst_byte_addr_nxt[c];
        size_r[c] <= size_nxt[c];
      end
      request_routing_reg_r <= request_routing_reg_nxt;
      armed_r <= armed_nxt;
      avs_readdata_r <= avs_readdata_nxt;
      ack_done_r <= ack_done_nxt;
      state_r <= state_nxt;
      chan_r <= chan_nxt;
      mem_addr_r <= mem_addr_nxt;
      mem_size_r <= mem_size_nxt;
    end
  end
endmodule
`default_nettype wire

// file: verification/dcr_monitor.sv
// Checker for the DMA routing block, bound to its top module.
`default_nettype none
module dcr_monitor #(
  parameter int unsigned NUM_REQ = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [NUM_REQ-1:0] periph_ack,
  input wire logic [NUM_REQ-1:0] periph_done,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ack_onehot_a: assert property ($onehot0(periph_ack))
    else $error("acknowledge on more than one peripheral");
  done_ack_a: assert property (periph_done == periph_ack)
    else $error("done differs from acknowledge");
  ack_cause_a: assert property (|periph_ack |-> mem_write && mem_ready)
    else $error("acknowledge outside a completed write");
  ack_given_a: assert property (mem_write && mem_ready |-> |periph_ack)
    else $error("completed write without acknowledge");
  rw_excl_a: assert property (!(mem_read && mem_write))
    else $error("read and write beats together");
  rd_hold_a: assert property (mem_read && !mem_ready |=>
    mem_read && $stable(mem_addr)) else $error("read beat not held");
  rd_to_wr_a: assert property (mem_read && mem_ready |=> mem_write)
    else $error("no write beat after read beat");
  wr_hold_a: assert property (mem_write && !mem_ready |=>
    mem_write && $stable(mem_addr)) else $error("write beat not held");
  rd_answer_a: assert property (avs_read && avs_waitrequest |=>
    !avs_waitrequest || !avs_read) else $error("register read stalls");
  wr_nowait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("register write stalled");
  cover property (mem_write && mem_ready);
  cover property (mem_read && !mem_ready);
  cover property (avs_read && !avs_waitrequest);
endmodule
bind dcr_top dcr_monitor #(.NUM_REQ(NUM_REQ)) dcr_monitor_inst (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .periph_ack(periph_ack), .periph_done(periph_done),
  .mem_read(mem_read), .mem_write(mem_write), .mem_addr(mem_addr),
  .mem_ready(mem_ready));
`default_nettype wire

// file: verification/dcr_periph_model.sv
// Peripheral and memory model on the far side of the engine.
`default_nettype none
module dcr_periph_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [3:0] req_idx,
  input wire logic raise,
  input wire logic [1:0] ready_delay,
  input wire logic [15:0] periph_ack,
  input wire logic mem_read,
  input wire logic mem_write,
  output logic [15:0] periph_req,
  output logic mem_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend_r;
  logic [1:0] cnt_r;
  // A request stays up until its own acknowledge, as a real peripheral.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pend_r <= 1'b0;
      cnt_r <= 2'h0;
      mem_ready <= 1'b0;
    end else begin
      if (raise) begin
        pend_r <= 1'b1;
      end else if (periph_ack[req_idx]) begin
        pend_r <= 1'b0;
      end
      mem_ready <= 1'b0;
      if ((mem_read || mem_write) && !mem_ready) begin
        if (cnt_r == ready_delay) begin
          mem_ready <= 1'b1;
          cnt_r <= 2'h0;
        end else begin
          cnt_r <= cnt_r + 2'h1;
        end
      end
    end
  end
  assign periph_req = pend_r ? (16'h1 << req_idx) : 16'h0;
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking testbench for the DMA routing block.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] avs_address = 10'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] periph_req, periph_ack, periph_done;
  logic mem_read, mem_write, mem_ready;
  logic [31:0] mem_addr;
  logic [1:0] mem_size;
  logic [3:0] req_idx = 4'h0;
  logic raise = 1'b0;
  logic [1:0] ready_delay = 2'h0;
  int fail_count = 0;
  int samples_checked = 0;
  always #20 clk_sys = ~clk_sys;
  dcr_top dcr_top_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .periph_req(periph_req), .periph_ack(periph_ack),
    .periph_done(periph_done), .mem_read(mem_read), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_size(mem_size), .mem_ready(mem_ready));
  dcr_periph_model dcr_periph_model_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .req_idx(req_idx), .raise(raise),
    .ready_delay(ready_delay), .periph_ack(periph_ack),
    .mem_read(mem_read), .mem_write(mem_write), .periph_req(periph_req),
    .mem_ready(mem_ready));
  task automatic give_verdict();
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  // One register access, started just after a rising edge. The request is
  // held until the edge at which waitrequest is sampled low; data are taken
  // there, and one idle edge follows so strobes never toggle in one step.
  task automatic bus(logic wr, int idx, logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    q = 32'h0000_0000;
    avs_address <= idx[9:0];
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge clk_sys);
    end
    if (n >= 20) begin
      fail_count++;
      give_verdict();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Looks at rising edges until the watched beat completes or times out.
  task automatic wait_beat(logic rd);
    int n;
    n = 0;
    while (((rd ? mem_read : mem_write) & mem_ready) !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_sys);
    end
    if (n >= 50) begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic s_map();
    logic [31:0] q;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, dcr_pkg::SRC_IDX_BASE + 8 * i, 32'h1111_0000 + i, q);
      bus(1'b1, dcr_pkg::DST_IDX_BASE + 8 * i, 32'h2222_0000 + i, q);
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, dcr_pkg::SRC_IDX_BASE + 8 * i, 32'h0, q);
      chk("src", 32'h1111_0000 + i, q);
      bus(1'b0, dcr_pkg::DST_IDX_BASE + 8 * i, 32'h0, q);
      chk("dst", 32'h2222_0000 + i, q);
    end
    avs_byteenable <= 4'h3;
    bus(1'b1, dcr_pkg::SRC_IDX_BASE, 32'h5555_aaaa, q);
    avs_byteenable <= 4'hf;
    bus(1'b0, dcr_pkg::SRC_IDX_BASE, 32'h0, q);
    chk("src lanes", 32'h1111_aaaa, q);
    bus(1'b1, 10'h3ff, 32'hdead_beef, q);
    bus(1'b0, 10'h3ff, 32'h0, q);
    chk("unmapped", dcr_pkg::UNMAPPED_RD, q);
  endtask
  // Every select code on channel 3, with varying size and answer delay.
  task automatic s_route(int code);
    logic [31:0] q, src, dst;
    logic [1:0] sz;
    sz = 2'(code % 3);
    src = 32'h0000_4000 + 4 * code;
    dst = 32'h0000_6000 + 8 * code;
    bus(1'b1, dcr_pkg::SRC_IDX_BASE + 24, src, q);
    bus(1'b1, dcr_pkg::DST_IDX_BASE + 24, dst, q);
    bus(1'b1, dcr_pkg::ROUTE_IDX, 32'(code) << 12, q);
    ready_delay <= 2'(code);
    req_idx <= code[3:0];
    raise <= 1'b1;
    @(posedge clk_sys);
    raise <= 1'b0;
    bus(1'b1, dcr_pkg::CTRL_IDX, (32'h1 << (dcr_pkg::CTRL_START_LSB + 3))
      | (32'(sz) << (dcr_pkg::CTRL_SIZE_LSB + 6)), q);
    wait_beat(1'b1);
    chk("read addr", src, mem_addr);
    chk("size", 32'(sz), 32'(mem_size));
    wait_beat(1'b0);
    chk("write addr", dst, mem_addr);
    chk("ack", 32'(16'h1 << code), 32'(periph_ack));
    chk("done", 32'(16'h1 << code), 32'(periph_done));
    bus(1'b0, dcr_pkg::SRC_IDX_BASE + 24, 32'h0, q);
    chk("src advanced", src + (32'h1 << sz), q);
    bus(1'b0, dcr_pkg::DST_IDX_BASE + 24, 32'h0, q);
    chk("dst advanced", dst + (32'h1 << sz), q);
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    s_map();
    for (int c = 0; c < 16; c++) begin
      s_route(c);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
